// ---- core/tbp_defs.svh ----
// Constants for the block-protocol reader controller
`ifndef TBP_DEFS_SVH
`define TBP_DEFS_SVH
`define TBP_PCB_I_BASE 8'h02
`define TBP_PCB_R_ACK 8'hA2
`define TBP_PCB_R_NAK 8'hB2
`define TBP_PCB_S_DESEL 8'hC2
`define TBP_PCB_CHAIN_BIT 4
`define TBP_PCB_NAK_BIT 4
`define TBP_PCB_BN_BIT 0
`define TBP_CLA_FIXED 8'h00
`define TBP_BN_INIT 1'b0
`define TBP_MAX_CHUNK 8'h40
`define TBP_FWT_NS 302000
`define TBP_CLK_NS 5
`define TBP_FWT_CYC (`TBP_FWT_NS / `TBP_CLK_NS)
`define TBP_RETRY_MAX 4'h3
`endif

// ---- core/tbp_pcb_decode.sv ----
// Classifier for a received protocol control byte
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.svh"
module tbp_pcb_decode
	import tbp_pkg::*;
(
	input wire logic [7:0] pcb,
	output var tbp_blk_t blk,
	output logic chain,
	output logic nak,
	output logic bn
);
	// Top two bits select the block family
	always_comb begin
		unique case (pcb[7:6])
			2'b00: blk = (pcb[5] == 1'b0 && pcb[1]) ? TBP_BLK_I : TBP_BLK_BAD;
			2'b10: blk = (pcb[5] && pcb[1]) ? TBP_BLK_R : TBP_BLK_BAD;
			2'b11: blk = TBP_BLK_S;
			2'b01: blk = TBP_BLK_BAD;
		endcase
	end
	assign chain = pcb[`TBP_PCB_CHAIN_BIT];
	assign nak = pcb[`TBP_PCB_NAK_BIT];
	assign bn = pcb[`TBP_PCB_BN_BIT];
endmodule
`default_nettype wire

// ---- core/tbp_pkg.sv ----
// Types for the block-protocol reader controller
package tbp_pkg;
	typedef enum logic [1:0] {TBP_BLK_I, TBP_BLK_R, TBP_BLK_S, TBP_BLK_BAD} tbp_blk_t;
	typedef enum logic [2:0] {TBP_ST_IDLE, TBP_ST_SEND, TBP_ST_WAIT, TBP_ST_RACK,
		TBP_ST_DESEL, TBP_ST_DONE} tbp_state_t;
endpackage

// ---- core/tbp_reader_ctrl.sv ----
// Reader-side block protocol controller framing command APDUs
// How it works
// - Reader always opens the block exchange
// - Chained I-block received gets R(ACK)
// - S-blocks paired; only DESELECT used
// - Illegal block or timeout sends R(NAK)
// - Error frame or timeout during tag chaining sends R(ACK)
// - ACK with other number: resend I-block
// - ACK with own number: next chained block
// - Failed DESELECT: resend or give up
// - APDU: CLA 00, INS, P1, P2, Lc, data, Le
// - Lc and data only when data exists
// - Le only when response data expected
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.svh"
module tbp_reader_ctrl
	import tbp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// User command side
	input wire logic cmd_start,
	input wire logic cmd_deselect,
	input wire logic [7:0] cmd_ins,
	input wire logic [7:0] cmd_p1,
	input wire logic [7:0] cmd_p2,
	input wire logic [7:0] cmd_lc,
	input wire logic [7:0] cmd_le,
	input wire logic cmd_has_le,
	input wire logic cmd_dat_valid,
	input wire logic [7:0] cmd_dat,
	output logic cmd_dat_ready,
	output logic busy,
	output logic done,
	output logic fail,
	output logic [7:0] rsp_dat,
	output logic rsp_dat_valid,
	output logic [7:0] rsp_sw1_ff,
	output logic [7:0] rsp_sw2_ff,
	// Frame link to the tag (byte stream, one frame per block)
	output logic tx_valid,
	output logic [7:0] tx_byte,
	output logic tx_last,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_last,
	input wire logic rx_err
);
	//////////////////////////////////////////////////////////////////////
	tbp_state_t state_ff, nxt_state;
	logic bn_ff;
	logic [7:0] sent_ff;
	logic [8:0] idx_ff;
	logic [8:0] blen_ff;
	logic [7:0] pcb_ff;
	logic [7:0] hdr_ff [0:4];
	logic [7:0] data_ff [0:255];
	logic [8:0] total_ff;
	logic [8:0] base_ff;
	logic first_rx_ff;
	logic [7:0] rx_pcb_ff;
	logic tag_chain_ff;
	logic [31:0] fwt_ff;
	logic [3:0] retry_ff;
	logic [7:0] hold_ff;
	logic hold_v_ff;
	logic [7:0] done_pipe_ff;
	logic done_ff, fail_ff;
	logic [8:0] load_ff;
	tbp_blk_t rx_blk;
	logic rx_chain, rx_nak, rx_bn;
	logic fwt_hit, frame_end, bad_end;
	logic [8:0] apdu_len;
	logic [7:0] dec_pcb;

	// A one-byte frame ends on its PCB, before rx_pcb_ff can hold it
	assign dec_pcb = first_rx_ff ? rx_byte : rx_pcb_ff;

	tbp_pcb_decode u_dec (
		.pcb(dec_pcb),
		.blk(rx_blk),
		.chain(rx_chain),
		.nak(rx_nak),
		.bn(rx_bn)
	);

	//////////////////////////////////////////////////////////////////////
	// APDU length with optional Lc, data and Le
	assign apdu_len = 9'd4 + ((cmd_lc != 8'h00) ? 9'd1 + {1'b0, cmd_lc} : 9'd0)
		+ (cmd_has_le ? 9'd1 : 9'd0);
	assign fwt_hit = (state_ff == TBP_ST_WAIT) && (fwt_ff == `TBP_FWT_CYC);
	assign frame_end = rx_valid && rx_last && (state_ff == TBP_ST_WAIT);
	assign bad_end = frame_end && rx_err;
	assign cmd_dat_ready = (state_ff == TBP_ST_IDLE) && (load_ff < {1'b0, cmd_lc});
	assign busy = (state_ff != TBP_ST_IDLE);
	assign done = done_ff;
	assign fail = fail_ff;
	assign rsp_dat = hold_ff;
	assign rsp_dat_valid = hold_v_ff;

	// Command data is loaded into the local array before start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_ff <= 9'h000;
		end else if (ce) begin
			if (state_ff == TBP_ST_DONE)
				load_ff <= 9'h000;
			else if (cmd_dat_valid && cmd_dat_ready)
				load_ff <= load_ff + 9'h001;
		end
	end
	always_ff @(posedge clk) begin
		if (ce && cmd_dat_valid && cmd_dat_ready)
			data_ff[load_ff[7:0]] <= cmd_dat;
	end

	// Header capture, CLA fixed to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 5; i++)
				hdr_ff[i] <= 8'h00;
			total_ff <= 9'h000;
		end else if (ce && state_ff == TBP_ST_IDLE && cmd_start) begin
			hdr_ff[0] <= `TBP_CLA_FIXED;
			hdr_ff[1] <= cmd_ins;
			hdr_ff[2] <= cmd_p1;
			hdr_ff[3] <= cmd_p2;
			hdr_ff[4] <= cmd_lc;
			total_ff <= apdu_len;
		end
	end

	// APDU byte at a given offset
	function automatic logic [7:0] apdu_byte(input logic [8:0] off);
		logic [8:0] dlen;
		dlen = (hdr_ff[4] != 8'h00) ? {1'b0, hdr_ff[4]} : 9'd0;
		if (off < 9'd4)
			apdu_byte = hdr_ff[off[1:0]];
		else if (dlen != 9'd0 && off == 9'd4)
			apdu_byte = hdr_ff[4]; // Lc only when data present
		else if (dlen != 9'd0 && off < 9'd5 + dlen)
			apdu_byte = data_ff[8'(off - 9'd5)];
		else
			apdu_byte = cmd_le; // Le only when flagged
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Main sequencer; reader always speaks first
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			TBP_ST_IDLE: if (cmd_deselect) nxt_state = TBP_ST_DESEL;
				else if (cmd_start) nxt_state = TBP_ST_SEND;
			TBP_ST_SEND, TBP_ST_RACK, TBP_ST_DESEL:
				if (tx_valid && tx_ready && tx_last) nxt_state = TBP_ST_WAIT;
			TBP_ST_WAIT: begin
				if (retry_ff > `TBP_RETRY_MAX)
					nxt_state = TBP_ST_DONE;
				else if (bad_end || fwt_hit)
					nxt_state = (pcb_ff == `TBP_PCB_S_DESEL) ? TBP_ST_DESEL : TBP_ST_RACK;
				else if (frame_end && rx_blk == TBP_BLK_I)
					nxt_state = rx_chain ? TBP_ST_RACK : TBP_ST_DONE;
				else if (frame_end)
					nxt_state = (rx_blk == TBP_BLK_R) ? TBP_ST_SEND :
						(rx_blk == TBP_BLK_S) ? TBP_ST_DONE : TBP_ST_RACK;
			end
			TBP_ST_DONE: nxt_state = TBP_ST_IDLE;
		endcase
	end

	// Transmit framing for I, R and S blocks
	always_comb begin
		tx_valid = 1'b0;
		tx_byte = 8'h00;
		tx_last = 1'b0;
		if (state_ff == TBP_ST_SEND) begin
			tx_valid = 1'b1;
			tx_byte = (idx_ff == 9'h000) ? pcb_ff : apdu_byte(base_ff + idx_ff - 9'h001);
			tx_last = (idx_ff == blen_ff);
		end else if (state_ff == TBP_ST_RACK || state_ff == TBP_ST_DESEL) begin
			tx_valid = 1'b1;
			tx_byte = pcb_ff;
			tx_last = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_ff <= TBP_ST_IDLE;
		else if (ce)
			state_ff <= nxt_state;
	end

	// Byte index in the current frame; first frame byte is PCB
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idx_ff <= 9'h000;
			first_rx_ff <= 1'b1;
		end else if (ce) begin
			if (tx_valid && tx_ready)
				idx_ff <= tx_last ? 9'h000 : idx_ff + 9'h001;
			if (state_ff == TBP_ST_WAIT && rx_valid)
				first_rx_ff <= rx_last;
			else if (state_ff != TBP_ST_WAIT)
				first_rx_ff <= 1'b1;
		end
	end

	// Frame wait timer, restarted on every block sent
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			fwt_ff <= 32'h0;
		else if (ce)
			fwt_ff <= (state_ff == TBP_ST_WAIT && !fwt_hit) ? fwt_ff + 32'h1 : 32'h0;
	end

	// Received PCB and byte holding; last two bytes become SW1, SW2
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_pcb_ff <= 8'h00;
			hold_ff <= 8'h00;
			hold_v_ff <= 1'b0;
			rsp_sw1_ff <= 8'h00;
			rsp_sw2_ff <= 8'h00;
		end else if (ce) begin
			hold_v_ff <= 1'b0;
			if (state_ff == TBP_ST_WAIT && rx_valid && !rx_err) begin
				if (first_rx_ff)
					rx_pcb_ff <= rx_byte;
				else begin
					rsp_sw1_ff <= rsp_sw2_ff;
					rsp_sw2_ff <= rx_byte;
					hold_ff <= rsp_sw1_ff;
					hold_v_ff <= !first_rx_ff && (done_pipe_ff > 8'h01);
				end
			end
		end
	end

	// Counts INF bytes seen so the two-byte status tail is held back
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			done_pipe_ff <= 8'h00;
		else if (ce) begin
			if (state_ff != TBP_ST_WAIT || (rx_valid && rx_last))
				done_pipe_ff <= 8'h00;
			else if (rx_valid && !first_rx_ff && done_pipe_ff != 8'hFF)
				done_pipe_ff <= done_pipe_ff + 8'h01;
		end
	end

	// Block handling on frame end or timeout
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bn_ff <= `TBP_BN_INIT;
			pcb_ff <= 8'h00;
			base_ff <= 9'h000;
			blen_ff <= 9'h000;
			sent_ff <= 8'h00;
			tag_chain_ff <= 1'b0;
			retry_ff <= 4'h0;
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
		end else if (ce) begin
			done_ff <= 1'b0;
			fail_ff <= 1'b0;
			if (state_ff == TBP_ST_IDLE && cmd_deselect) begin
				pcb_ff <= `TBP_PCB_S_DESEL; // Paired S request
				retry_ff <= 4'h0;
			end else if (state_ff == TBP_ST_IDLE && cmd_start) begin
				base_ff <= 9'h000;
				blen_ff <= (apdu_len > 9'(`TBP_MAX_CHUNK)) ? 9'(`TBP_MAX_CHUNK) : apdu_len;
				pcb_ff <= `TBP_PCB_I_BASE | {3'b000, apdu_len > 9'(`TBP_MAX_CHUNK), 3'b000, bn_ff};
				retry_ff <= 4'h0;
				tag_chain_ff <= 1'b0;
			end else if (state_ff == TBP_ST_WAIT && (bad_end || fwt_hit)) begin
				retry_ff <= retry_ff + 4'h1;
				if (pcb_ff == `TBP_PCB_S_DESEL)
					pcb_ff <= `TBP_PCB_S_DESEL; // Resend DESELECT as is
				else if (tag_chain_ff)
					pcb_ff <= `TBP_PCB_R_ACK | {7'h00, bn_ff};
				else
					pcb_ff <= `TBP_PCB_R_NAK | {7'h00, bn_ff};
			end else if (frame_end && !rx_err) begin
				retry_ff <= 4'h0;
				unique case (rx_blk)
					TBP_BLK_S: begin
						bn_ff <= `TBP_BN_INIT; // Deselected, next activation restarts
						done_ff <= 1'b1;
					end
					TBP_BLK_I: begin
						bn_ff <= ~bn_ff;
						tag_chain_ff <= rx_chain;
						if (rx_chain)
							pcb_ff <= `TBP_PCB_R_ACK | {7'h00, ~bn_ff};
						else
							done_ff <= 1'b1;
					end
					TBP_BLK_R: begin
						if (!rx_nak && rx_bn == bn_ff) begin
							// Own number acknowledged: next chunk
							bn_ff <= ~bn_ff;
							base_ff <= base_ff + blen_ff;
							blen_ff <= (total_ff - base_ff - blen_ff > 9'(`TBP_MAX_CHUNK)) ?
								9'(`TBP_MAX_CHUNK) : total_ff - base_ff - blen_ff;
							pcb_ff <= `TBP_PCB_I_BASE | {3'b000,
								total_ff - base_ff - blen_ff > 9'(`TBP_MAX_CHUNK), 3'b000, ~bn_ff};
						end else begin
							// NAK or other number: resend last I-block
							pcb_ff <= `TBP_PCB_I_BASE | {3'b000, base_ff + blen_ff < total_ff,
								3'b000, bn_ff};
						end
					end
					TBP_BLK_BAD: pcb_ff <= `TBP_PCB_R_NAK | {7'h00, bn_ff};
				endcase
			end
			if (state_ff == TBP_ST_WAIT && retry_ff > `TBP_RETRY_MAX)
				fail_ff <= 1'b1; // Give up on the tag
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Protocol checks; all state lives on clk
	default clocking cb_main @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_good_end; ce && frame_end && !rx_err; endsequence
	sequence s_bad_end; ce && bad_end && !tag_chain_ff; endsequence
	chk_idle_quiet: assert property (state_ff == TBP_ST_IDLE |-> !tx_valid)
		else $error("Frame sent while idle");
	chk_cla_first: assert property (state_ff == TBP_ST_SEND && base_ff == 9'h000
		&& idx_ff == 9'h001 |-> tx_byte == `TBP_CLA_FIXED)
		else $error("Class byte not fixed");
	chk_desel_pair: assert property (state_ff == TBP_ST_DESEL
		|-> tx_last && tx_byte == `TBP_PCB_S_DESEL)
		else $error("Deselect frame malformed");
	chk_nak_bad: assert property (s_bad_end ##0 (pcb_ff != `TBP_PCB_S_DESEL
		&& retry_ff <= `TBP_RETRY_MAX) |=> tx_valid && (tx_byte & 8'hFE) == `TBP_PCB_R_NAK)
		else $error("Bad frame not refused");
	chk_next_chunk: assert property (s_good_end ##0 (rx_blk == TBP_BLK_R && !rx_nak
		&& rx_bn == bn_ff) |=> state_ff == TBP_ST_SEND && bn_ff != $past(bn_ff))
		else $error("Chaining did not continue");
	chk_sw_tail: assert property (s_good_end ##0 (rx_blk == TBP_BLK_I && !rx_chain)
		|=> rsp_sw2_ff == $past(rx_byte) && done)
		else $error("Status tail not kept");
endmodule
`default_nettype wire

// ---- verification/tbp_reader_ctrl_bench.sv ----
// Self-checking bench: reader controller against a behavioural tag
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.svh"
module tbp_reader_ctrl_bench;
	logic clk, rst, ce, cmd_start, cmd_deselect, cmd_has_le, cmd_dat_valid;
	logic [7:0] cmd_ins, cmd_p1, cmd_p2, cmd_lc, cmd_le, cmd_dat;
	logic [7:0] rsp_dat, rsp_sw1_ff, rsp_sw2_ff, tx_byte, rx_byte;
	logic cmd_dat_ready, busy, done, fail, rsp_dat_valid, tx_valid, tx_last, tx_ready;
	logic rx_valid, rx_last, rx_err;
	logic [7:0] rsp_q[$];
	int fails, check_count;
	tbp_reader_ctrl i_tbp_reader_ctrl (.clk, .rst, .ce, .cmd_start, .cmd_deselect,
		.cmd_ins, .cmd_p1, .cmd_p2, .cmd_lc, .cmd_le, .cmd_has_le, .cmd_dat_valid,
		.cmd_dat, .cmd_dat_ready, .busy, .done, .fail, .rsp_dat, .rsp_dat_valid,
		.rsp_sw1_ff, .rsp_sw2_ff, .tx_valid, .tx_byte, .tx_last, .tx_ready,
		.rx_valid, .rx_byte, .rx_last, .rx_err);
	tbp_tag_model i_tbp_tag_model (.clk, .rst, .tx_valid, .tx_byte, .tx_last,
		.tx_ready, .rx_valid, .rx_byte, .rx_last, .rx_err);
	////////////////////////////////////////////////////////////
	// 200 MHz clock
	always #2.5 clk = ~clk;
	// Response bytes arrive as one-cycle pulses; a refused frame's bytes are dropped
	always @(posedge clk) begin
		if (rsp_dat_valid === 1'b1) rsp_q.push_back(rsp_dat);
		if (rx_valid === 1'b1 && rx_last === 1'b1 && rx_err === 1'b1) rsp_q.delete();
	end
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			fails++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded wait for the completion pulse
	task automatic wait_end();
		int n;
		n = 0;
		while (done !== 1'b1 && fail !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			fails++;
			$display("Error at %0t: no completion", $time);
			tally_and_finish();
		end
	endtask
	// Load data, start, then compare framed bytes and response
	task automatic exchange(input logic [7:0] ins, input logic [7:0] lc, input logic has_le);
		logic [7:0] exp[$];
		logic ok;
		int n;
		exp = {`TBP_CLA_FIXED, ins, 8'h12, 8'h34};
		i_tbp_tag_model.apdu.delete();
		i_tbp_tag_model.pcbs.delete();
		rsp_q.delete();
		repeat (2) @(posedge clk);
		cmd_ins <= ins;
		cmd_lc <= lc;
		cmd_has_le <= has_le;
		if (lc != 8'h00) exp.push_back(lc);
		for (int i = 0; i < lc; i++) begin
			cmd_dat <= 8'h40 + 8'(i);
			cmd_dat_valid <= 1'b1;
			exp.push_back(8'h40 + 8'(i));
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (cmd_dat_ready !== 1'b1 && n < 8);
		end
		cmd_dat_valid <= 1'b0;
		if (has_le) exp.push_back(cmd_le);
		cmd_start <= 1'b1;
		@(posedge clk);
		cmd_start <= 1'b0;
		wait_end();
		ok = (done === 1'b1) && (exp.size() == i_tbp_tag_model.apdu.size());
		foreach (exp[i]) begin
			if (i_tbp_tag_model.apdu[i] !== exp[i]) ok = 1'b0;
		end
		check(ok, "command bytes wrong");
		// Last data byte is pushed at the edge after the done pulse
		@(posedge clk);
		check(rsp_sw1_ff === 8'h90 && rsp_sw2_ff === 8'h00, "status bad");
		check(rsp_q.size() == 2 && rsp_q[0] === 8'hD0 && rsp_q[1] === 8'hD1, "data bad");
	endtask
	// Select, read and write, with and without data or length
	task automatic sc_commands();
		logic [7:0] ins[3] = '{8'hA4, 8'hB0, 8'hD6};
		logic [7:0] lcs[3] = '{8'h02, 8'h00, 8'h04};
		for (int k = 0; k < 3; k++) begin
			exchange(ins[k], lcs[k], lcs[k] == 8'h00);
			check(i_tbp_tag_model.pcbs[0][7:6] === 2'b00, "no opening block");
		end
	endtask
	// Long write split into chained blocks
	task automatic sc_chain();
		exchange(8'hD6, 8'h64, 1'b0);
		check(i_tbp_tag_model.pcbs[0][4] === 1'b1, "no chaining");
	endtask
	// Corrupted answer must be refused and recovered
	task automatic sc_err();
		logic hit;
		hit = 1'b0;
		i_tbp_tag_model.inject_err = 1'b1;
		exchange(8'hB0, 8'h00, 1'b1);
		foreach (i_tbp_tag_model.pcbs[i]) begin
			if ((i_tbp_tag_model.pcbs[i] & 8'hFE) === `TBP_PCB_R_NAK) hit = 1'b1;
		end
		check(hit, "no refusal");
	endtask
	// Deselect then a fresh exchange
	task automatic sc_desel();
		i_tbp_tag_model.pcbs.delete();
		@(posedge clk);
		cmd_deselect <= 1'b1;
		@(posedge clk);
		cmd_deselect <= 1'b0;
		wait_end();
		check(done === 1'b1 && i_tbp_tag_model.pcbs[0] === `TBP_PCB_S_DESEL, "bad deselect");
		exchange(8'hB0, 8'h00, 1'b1);
	endtask
	initial begin
		{clk, cmd_start, cmd_deselect, cmd_has_le, cmd_dat_valid} = '0;
		{cmd_ins, cmd_lc, cmd_dat} = '0;
		cmd_p1 = 8'h12;
		cmd_p2 = 8'h34;
		cmd_le = 8'h02;
		rst = 1'b1;
		ce = 1'b1;
		fails = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		sc_commands();
		sc_chain();
		sc_err();
		sc_desel();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ---- verification/tbp_tag_model.sv ----
// Behavioural tag answering the reader's block protocol
`timescale 1ns/1ps
`default_nettype none
`include "tbp_defs.svh"
module tbp_tag_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic tx_last,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic rx_last,
	output logic rx_err
);
	logic bn_ff, inject_err;
	logic [7:0] fr[$], rsp[$], last_i[$], apdu[$], pcbs[$];
	////////////////////////////////////////////////////////////
	// One frame in, one frame out; no wait extension ever
	task automatic reply();
		logic [7:0] pcb;
		pcb = fr.pop_front();
		pcbs.push_back(pcb);
		if (pcb[7:6] == 2'b00) begin
			bn_ff = ~bn_ff;
			apdu = {apdu, fr};
			if (pcb[`TBP_PCB_CHAIN_BIT]) begin
				rsp = {`TBP_PCB_R_ACK | 8'(bn_ff)};
			end else begin
				last_i = {`TBP_PCB_I_BASE | 8'(bn_ff), 8'hD0, 8'hD1, 8'h90, 8'h00};
				rsp = last_i;
			end
		end else if (pcb[7:6] == 2'b10) begin
			// Matching number means our last block was lost
			if (pcb[0] == bn_ff || !pcb[`TBP_PCB_NAK_BIT]) begin
				rsp = last_i;
			end else begin
				rsp = {`TBP_PCB_R_ACK | 8'(bn_ff)};
			end
		end else begin
			rsp = {`TBP_PCB_S_DESEL};
			bn_ff = 1'b1;
		end
		fr.delete();
		repeat (4) @(posedge clk);
		foreach (rsp[i]) begin
			rx_valid <= 1'b1;
			rx_byte <= rsp[i];
			rx_last <= (i == rsp.size() - 1);
			rx_err <= inject_err && (i == rsp.size() - 1);
			@(posedge clk);
		end
		// Released line shows the inverse, never a stale byte
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_err <= 1'b0;
		rx_byte <= ~rsp[rsp.size() - 1];
		inject_err = 1'b0;
	endtask
	// Capture frames; ready drops every other cycle to stall the reader
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_last = 1'b0;
		rx_err = 1'b0;
		bn_ff = 1'b1;
		inject_err = 1'b0;
		forever begin
			@(posedge clk);
			tx_ready <= ~tx_ready & ~rst;
			if (rst) begin
				bn_ff = 1'b1;
			end else if (tx_valid && tx_ready) begin
				fr.push_back(tx_byte);
				if (tx_last) reply(); // only ever answers
			end
		end
	end
endmodule
`default_nettype wire
